// ==== include/host_port_map.svh ====
// Purpose: named constants of the host port handshake block
// Assumes: included by bare name from the design files
// Notes:   definitions only, no logic
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// access_select encodings
`define ACC_CONTROL   2'h0
`define ACC_DATA_INC  2'h1
`define ACC_ADDRESS   2'h2
`define ACC_DATA_FIX  2'h3

// halfword_select value of the first half-word (low half)
`define HALF_FIRST    1'b0
// read_write_select value of a read
`define RW_READ       1'b1

// address step after an auto-incrementing word
`define ADDR_STEP     32'h0000_0004
`define WORD_RESET    32'h0000_0000
`define HALF_RESET    16'h0000

// synchronised pin vector: cs, ds1, ds2, as, acc[1:0], rw, hw, data[15:0]
`define PIN_WIDTH     24
`define PIN_RESET     24'hFF_0000
`define PIN_CS        23
`define PIN_DS1       22
`define PIN_DS2       21
`define PIN_AS        20
`define PIN_ACC_HI    19
`define PIN_ACC_LO    18
`define PIN_RW        17
`define PIN_HW        16
`define PIN_DATA_HI   15

// data lead of the read word before ready falls
`define CPU_PERIOD_NS  100
`define CLK_PERIOD_NS  100
`define PRESENT_CYCLES ((`CPU_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRES_CNT_LAST  4'(`PRESENT_CYCLES - 1)
`define PRES_CNT_ZERO  4'h0

// write FIFO shape: {address, data}
`define FIFO_WIDTH    64
`define FIFO_DEPTH    16

`endif

// ==== include/host_port_pkg.sv ====
// Purpose: shared types of the host port handshake block
// Assumes: nothing
// Notes:   constants live in host_port_map.svh
package host_port_pkg;
  // transfer sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_fetch,
    st_present,
    st_push
  } state_t;
endpackage

// ==== hw/host_port_fifo.sv ====
// Purpose: write FIFO between the host port and the word sink
// Assumes: one clock, asynchronous active-low reset
// Notes:   read data leave through a register stage
`timescale 1ns/100ps
module host_port_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];   // storage array
  logic [PW-1:0]    wr_ptr_q;        // next write slot
  logic [PW-1:0]    rd_ptr_q;        // next read slot
  logic [CW-1:0]    count_q;         // words held in the array
  logic             out_valid_q;     // output stage full
  logic [WIDTH-1:0] out_data_q;      // output stage word
  logic             push;            // word enters
  logic             load;            // word moves to the output stage

  assign in_ready  = (count_q != CW'(DEPTH));
  assign push      = in_valid && in_ready;
  assign load      = (count_q != '0) && (!out_valid_q || out_ready);
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

  // array write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
      end
      if (load) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
      end
      count_q <= count_q + CW'(push) - CW'(load);
    end
  end

  // registered output stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else begin
      out_valid_q <= load || (out_valid_q && !out_ready);
      if (load) begin
        out_data_q <= mem_q[rd_ptr_q];
      end
    end
  end
endmodule

// ==== hw/host_port_strobe_ready.sv ====
// Purpose: strobe combining, select capture and ready handshake of a 16-bit host port
// Assumes: 10 MHz clk, pins synchronised here, word fetch channel on clk
// Notes:   data words leave through a 16-word write FIFO
// Notes on behaviour
// - strobe low when selected and strobes differ
// - ready held low while chip select high
// - ready busy at select if transfer pending
// - first-half data read with no prefetched word requests fetch on strobe fall
// - ready busy until fetched word loaded
// - ready busy after second half-word of a data write or incrementing read completes
// - other accesses leave ready low
// - control and address accesses leave ready alone
// - read data driven from one clock after strobe fall to one clock after strobe rise
// - read data valid one period before ready
`timescale 1ns/100ps
`include "host_port_map.svh"
module host_port_strobe_ready (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        port_chip_select,
  input  wire logic        data_strobe_one,
  input  wire logic        data_strobe_two,
  input  wire logic        address_strobe_n,
  input  wire logic [1:0]  access_select,
  input  wire logic        read_write_select,
  input  wire logic        halfword_select,
  input  wire logic [15:0] port_data_bus_in,
  output      logic [15:0] port_data_bus_out,
  output      logic        port_data_bus_oe_n,
  output      logic        port_ready,
  output      logic        fetch_req,
  output      logic [31:0] fetch_addr,
  input  wire logic        fetch_valid,
  input  wire logic [31:0] fetch_data,
  output      logic        write_valid,
  input  wire logic        write_ready,
  output      logic [31:0] write_addr,
  output      logic [31:0] write_data
);
  import host_port_pkg::*;

  logic [`PIN_WIDTH-1:0] sync1_q;        // first synchroniser stage
  logic [`PIN_WIDTH-1:0] sync2_q;        // second synchroniser stage
  logic                  cs;             // synchronised chip select
  logic                  strobe;         // combined_access_strobe, active low
  logic                  strobe_q;       // previous strobe level
  logic                  as_q;           // previous address strobe level
  logic                  strobe_fall;    // access begins
  logic                  strobe_rise;    // access ends
  logic                  as_fall;        // address strobe frames the selects
  logic                  as_framed_q;    // selects held from address strobe
  logic [1:0]            as_acc_q;       // selects caught at address strobe
  logic                  as_rw_q;
  logic                  as_hw_q;
  logic [1:0]            acc_c;          // selects in force at strobe fall
  logic                  rw_c;
  logic                  hw_c;
  logic [1:0]            acc_q;          // selects of the running access
  logic                  rw_q;
  logic                  hw_q;
  logic                  cur_data;       // running access targets the data register
  logic                  new_data;       // starting access targets the data register
  state_t                state_q;        // transfer sequencer
  logic [3:0]            pres_cnt_q;     // lead counter before ready falls
  logic [15:0]           ctrl_q;         // port_control_register
  logic [31:0]           addr_q;         // port_address_register
  logic [31:0]           data_q;         // port_data_register
  logic [15:0]           hold_q;         // first half-word of a write
  logic                  prefetched_q;   // data_q holds the word at addr_q
  logic [15:0]           out_q;          // read data toward the pins
  logic                  drive_q;        // read data driven
  logic                  fifo_in_ready;  // FIFO accepts a word
  logic [63:0]           fifo_out;       // FIFO head {address, data}

  assign cs          = sync2_q[`PIN_CS];
  assign strobe      = ~(sync2_q[`PIN_DS1] ^ sync2_q[`PIN_DS2]) | cs;
  assign strobe_fall = strobe_q && !strobe;
  assign strobe_rise = !strobe_q && strobe;
  assign as_fall     = as_q && !sync2_q[`PIN_AS];
  // address strobe tied high never frames, so the access strobe does
  assign acc_c    = as_framed_q ? as_acc_q : sync2_q[`PIN_ACC_HI:`PIN_ACC_LO];
  assign rw_c     = as_framed_q ? as_rw_q : sync2_q[`PIN_RW];
  assign hw_c     = as_framed_q ? as_hw_q : sync2_q[`PIN_HW];
  assign cur_data = (acc_q == `ACC_DATA_INC) || (acc_q == `ACC_DATA_FIX);
  assign new_data = (acc_c == `ACC_DATA_INC) || (acc_c == `ACC_DATA_FIX);

  // ready is busy only while selected and a transfer runs
  assign port_ready = !cs && (state_q != st_idle);
  assign port_data_bus_out  = out_q;
  assign port_data_bus_oe_n = !drive_q;
  assign fetch_req  = (state_q == st_fetch);
  assign fetch_addr = addr_q;
  assign write_addr = fifo_out[63:32];
  assign write_data = fifo_out[31:0];

  // two-stage synchroniser on every host pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= `PIN_RESET;
      sync2_q <= `PIN_RESET;
    end else begin
      sync1_q <= {port_chip_select, data_strobe_one, data_strobe_two, address_strobe_n,
                  access_select, read_write_select, halfword_select, port_data_bus_in};
      sync2_q <= sync1_q;
    end
  end

  // edge history of the strobes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_q <= 1'b1;
      as_q     <= 1'b1;
    end else begin
      strobe_q <= strobe;
      as_q     <= sync2_q[`PIN_AS];
    end
  end

  // select capture at address strobe, and at access strobe fall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      as_framed_q <= 1'b0;
      as_acc_q    <= `ACC_CONTROL;
      as_rw_q     <= `RW_READ;
      as_hw_q     <= `HALF_FIRST;
      acc_q       <= `ACC_CONTROL;
      rw_q        <= `RW_READ;
      hw_q        <= `HALF_FIRST;
    end else begin
      if (as_fall) begin
        as_framed_q <= 1'b1;
        as_acc_q    <= sync2_q[`PIN_ACC_HI:`PIN_ACC_LO];
        as_rw_q     <= sync2_q[`PIN_RW];
        as_hw_q     <= sync2_q[`PIN_HW];
      end else if (strobe_rise) begin
        as_framed_q <= 1'b0;
      end
      if (strobe_fall) begin
        acc_q <= acc_c;
        rw_q  <= rw_c;
        hw_q  <= hw_c;
      end
    end
  end

  // transfer sequencer: fetch, present lead, write push
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= st_idle;
      pres_cnt_q <= `PRES_CNT_ZERO;
    end else begin
      case (state_q)
        st_idle: begin
          if (strobe_fall && new_data && rw_c == `RW_READ && hw_c == `HALF_FIRST && !prefetched_q) begin
            state_q <= st_fetch;
          end else if (strobe_rise && cur_data && hw_q != `HALF_FIRST) begin
            // fixed-address data reads fall through untouched
            if (rw_q != `RW_READ) begin
              state_q <= st_push;
            end else if (acc_q == `ACC_DATA_INC) begin
              state_q <= st_fetch;
            end
          end
        end
        st_fetch: begin
          if (fetch_valid) begin
            state_q    <= st_present;
            pres_cnt_q <= `PRES_CNT_ZERO;
          end
        end
        st_present: begin
          // word on the pins for a first-half read, ready falls after the lead
          if (pres_cnt_q == `PRES_CNT_LAST) begin
            state_q <= st_idle;
          end else begin
            pres_cnt_q <= pres_cnt_q + 4'h1;
          end
        end
        st_push: begin
          if (fifo_in_ready) begin
            state_q <= st_idle;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // address register: host writes and auto-increment steps
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= `WORD_RESET;
    end else if (strobe_rise && acc_q == `ACC_ADDRESS && rw_q != `RW_READ) begin
      if (hw_q == `HALF_FIRST) begin
        addr_q[15:0] <= sync2_q[`PIN_DATA_HI:0];
      end else begin
        addr_q[31:16] <= sync2_q[`PIN_DATA_HI:0];
      end
    end else if (state_q == st_push && fifo_in_ready && acc_q == `ACC_DATA_INC) begin
      addr_q <= addr_q + `ADDR_STEP;
    end else if (state_q == st_idle && strobe_rise && acc_q == `ACC_DATA_INC && rw_q == `RW_READ
                 && hw_q != `HALF_FIRST) begin
      addr_q <= addr_q + `ADDR_STEP;
    end
  end

  // control register, written by the host without touching ready
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `HALF_RESET;
    end else if (strobe_rise && acc_q == `ACC_CONTROL && rw_q != `RW_READ) begin
      ctrl_q <= sync2_q[`PIN_DATA_HI:0];
    end
  end

  // data register, write holding half and prefetch flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q       <= `WORD_RESET;
      hold_q       <= `HALF_RESET;
      prefetched_q <= 1'b0;
    end else begin
      if (state_q == st_fetch && fetch_valid) begin
        data_q       <= fetch_data;
        prefetched_q <= 1'b1;
      end else if (strobe_rise && cur_data && rw_q != `RW_READ) begin
        prefetched_q <= 1'b0;
        if (hw_q == `HALF_FIRST) begin
          hold_q <= sync2_q[`PIN_DATA_HI:0];
        end else begin
          data_q <= {sync2_q[`PIN_DATA_HI:0], hold_q};
        end
      end else if (strobe_rise && cur_data && hw_q != `HALF_FIRST) begin
        prefetched_q <= 1'b0;                                  // word consumed
      end else if (strobe_rise && acc_q == `ACC_ADDRESS && rw_q != `RW_READ) begin
        prefetched_q <= 1'b0;                                  // new address, stale word
      end
    end
  end

  // read data and bus drive: on after strobe fall, off after rise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_q   <= `HALF_RESET;
      drive_q <= 1'b0;
    end else begin
      if (strobe_fall && rw_c == `RW_READ) begin
        drive_q <= 1'b1;
        case (acc_c)
          `ACC_CONTROL: out_q <= ctrl_q;
          `ACC_ADDRESS: out_q <= (hw_c == `HALF_FIRST) ? addr_q[15:0] : addr_q[31:16];
          default:      out_q <= (hw_c == `HALF_FIRST) ? data_q[15:0] : data_q[31:16];
        endcase
      end else if (strobe_rise) begin
        drive_q <= 1'b0;
      end else if (state_q == st_fetch && fetch_valid && drive_q && cur_data && hw_q == `HALF_FIRST) begin
        // fetched word reaches the pins one clock before ready falls
        out_q <= fetch_data[15:0];
      end
    end
  end

  // completed write words wait here for the sink
  host_port_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (state_q == st_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({addr_q, data_q}),
    .out_valid (write_valid),
    .out_ready (write_ready),
    .out_data  (fifo_out)
  );
endmodule

// ==== sim/host_port_checker.sv ====
// Purpose: port-level checks of the host port handshake block
// Assumes: sees only the ports of host_port_strobe_ready
// Notes:   bound from the testbench file
`timescale 1ns/100ps
`include "host_port_map.svh"
module host_port_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        port_chip_select,
  input wire logic        data_strobe_one,
  input wire logic        data_strobe_two,
  input wire logic        read_write_select,
  input wire logic [15:0] port_data_bus_out,
  input wire logic        port_data_bus_oe_n,
  input wire logic        port_ready,
  input wire logic        fetch_req,
  input wire logic        write_valid,
  input wire logic        write_ready,
  input wire logic [31:0] write_addr,
  input wire logic [31:0] write_data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // access strobe as the pins form it, active low
  wire logic stb_n = ~(data_strobe_one ^ data_strobe_two) | port_chip_select;

  a_ready_cs_low: assert property (port_chip_select [*3] |-> !port_ready)
    else $error("ready busy while deselected");
  a_ready_cs_past: assert property (port_ready |-> !$past(port_chip_select, 2))
    else $error("ready busy without earlier select");
  a_fetch_busy: assert property (fetch_req && !port_chip_select && $past(port_chip_select, 2) == 1'b0
    |-> port_ready)
    else $error("ready low while a word is fetched");
  a_read_lead: assert property ($fell(port_ready) && !port_data_bus_oe_n |-> $stable(port_data_bus_out))
    else $error("read data changed as ready fell");
  a_drive_read: assert property ($fell(port_data_bus_oe_n) |-> read_write_select == `RW_READ)
    else $error("bus driven on a write");
  a_idle_release: assert property (stb_n [*6] |-> port_data_bus_oe_n)
    else $error("bus driven with strobe high");
  a_sink_hold: assert property (write_valid && !write_ready |=> write_valid && $stable(write_addr)
    && $stable(write_data))
    else $error("write word dropped under stall");
  a_busy_bounded: assert property (port_ready |-> ##[1:300] !port_ready)
    else $error("ready stuck busy");
endmodule

// ==== sim/host_port_far_side.sv ====
// Purpose: word fetch channel and write sink facing the host port
// Assumes: same clock as the block, fetched words made from the address
// Notes:   fetch data do not hold outside the valid pulse
`timescale 1ns/100ps
module host_port_far_side (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_addr,
  output      logic        fetch_valid,
  output      logic [31:0] fetch_data,
  input  wire logic        write_valid,
  output      logic        write_ready,
  input  wire logic [31:0] write_addr,
  input  wire logic [31:0] write_data,
  input  wire logic        slow,
  input  wire logic        stall
);
  logic [3:0]  wait_q;          // cycles spent on the current fetch
  logic [31:0] last_fetch;      // address of the last word served
  logic [31:0] got_addr [0:31]; // words accepted by the sink
  logic [31:0] got_data [0:31];
  int          n_got;           // count of accepted words
  // the sink stalls on command of the bench
  assign write_ready = !stall;
  // serve one word per request after a short or a long wait
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q      <= 4'h0;
      fetch_valid <= 1'b0;
      fetch_data  <= 32'hFFFF_FFFF;
      last_fetch  <= 32'h0;
    end else begin
      fetch_valid <= 1'b0;
      fetch_data  <= ~fetch_data; // no stale word outside the pulse
      if (fetch_req && !fetch_valid) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q == (slow ? 4'hC : 4'h1)) begin
          wait_q      <= 4'h0;
          fetch_valid <= 1'b1;
          fetch_data  <= {fetch_addr[15:0] ^ 16'h5A5A, fetch_addr[15:0]};
          last_fetch  <= fetch_addr;
        end
      end
    end
  end
  // record every word the sink takes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) n_got <= 0;
    else if (write_valid && write_ready) begin
      got_addr[n_got[4:0]] <= write_addr;
      got_data[n_got[4:0]] <= write_data;
      n_got                <= n_got + 1;
    end
  end
endmodule

// ==== sim/testbench.sv ====
// Purpose: self-checking bench of the host port handshake block
// Assumes: host pins driven here, fetch channel and sink in host_port_far_side
// Notes:   checker bound below the module
`timescale 1ns/100ps
`include "host_port_map.svh"
module testbench;
  logic        clk, reset_n, port_chip_select, data_strobe_one, data_strobe_two, address_strobe_n;
  logic [1:0]  access_select;
  logic        read_write_select, halfword_select, port_data_bus_oe_n, port_ready, fetch_req, fetch_valid;
  logic        write_valid, write_ready, slow, stall, bi, bo;
  logic [15:0] port_data_bus_in, port_data_bus_out, rd;
  logic [31:0] fetch_addr, fetch_data, write_addr, write_data, w;
  int          miscompares, cmp_count;
  host_port_strobe_ready uut (.*);
  host_port_far_side     far (.*);
  // free-running 10 MHz clock
  always #50 clk = ~clk;
  // word the fetch channel serves for an address
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[15:0] ^ 16'h5A5A, a[15:0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one half-word access; bi/bo report busy during and after the strobe
  task automatic access(input logic [1:0] acc, input logic rw, input logic hw, input logic [15:0] din,
                        input logic use_as, output logic [15:0] dout, output logic bi, output logic bo);
    int n;
    bi = 1'b0;
    bo = 1'b0;
    n  = 0;
    @(posedge clk);
    access_select     <= acc;
    read_write_select <= rw;
    halfword_select   <= hw;
    port_data_bus_in  <= din;
    port_chip_select  <= 1'b0;
    address_strobe_n  <= !use_as;
    repeat (5) @(posedge clk);
    if (use_as) begin
      access_select     <= `ACC_DATA_INC;
      read_write_select <= `RW_READ;
    end
    data_strobe_two <= 1'b0;
    repeat (6) begin
      @(negedge clk);
      bi = bi | port_ready;
    end
    while (port_ready !== 1'b0 && n < 200) begin
      @(negedge clk);
      bi = 1'b1;
      n++;
    end
    check({31'h0, port_ready}, 32'h0);
    dout = port_data_bus_out;
    @(posedge clk);
    data_strobe_two  <= 1'b1;
    address_strobe_n <= 1'b1;
    repeat (8) begin
      @(negedge clk);
      bo = bo | port_ready;
    end
    @(posedge clk);
    port_chip_select <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic set_addr(input logic [31:0] a);
    access(`ACC_ADDRESS, 1'b0, 1'b0, a[15:0], 1'b0, rd, bi, bo);
    check({30'h0, bi, bo}, 32'h0);
    access(`ACC_ADDRESS, 1'b0, 1'b1, a[31:16], 1'b0, rd, bi, bo);
    check({30'h0, bi, bo}, 32'h0);
  endtask
  task automatic control_regs;
    access(`ACC_CONTROL, 1'b0, 1'b0, 16'h1234, 1'b0, rd, bi, bo);
    access(`ACC_CONTROL, `RW_READ, 1'b0, 16'h0, 1'b0, rd, bi, bo);
    check({14'h0, bi, bo, rd}, 32'h0000_1234);
    access(`ACC_CONTROL, 1'b0, 1'b0, 16'hBEEF, 1'b1, rd, bi, bo);
    access(`ACC_CONTROL, `RW_READ, 1'b0, 16'h0, 1'b0, rd, bi, bo);
    check({16'h0, rd}, 32'h0000_BEEF);
  endtask
  task automatic reads;
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      set_addr(32'h0000_0100);
      w = mem_word(32'h0000_0100);
      access(`ACC_DATA_INC, `RW_READ, 1'b0, 16'h0, 1'b0, rd, bi, bo);
      check({15'h0, bi, rd}, {15'h1, w[15:0]});
      check(far.last_fetch, 32'h0000_0100);
      access(`ACC_DATA_INC, `RW_READ, 1'b1, 16'h0, 1'b0, rd, bi, bo);
      check({15'h0, bo, rd}, {15'h1, w[31:16]});
      w = mem_word(32'h0000_0104);
      access(`ACC_DATA_INC, `RW_READ, 1'b0, 16'h0, 1'b0, rd, bi, bo);
      check({16'h0, rd}, {16'h0, w[15:0]});
      set_addr(32'h0000_0200);
      w = mem_word(32'h0000_0200);
      access(`ACC_DATA_FIX, `RW_READ, 1'b0, 16'h0, 1'b0, rd, bi, bo);
      check({15'h0, bi, rd}, {15'h1, w[15:0]});
    end
  endtask
  task automatic fill_drain;
    int   i;
    logic full;
    full = 1'b0;
    set_addr(32'h0000_0040);
    stall <= 1'b1;
    for (i = 0; i < 20 && !full; i++) begin
      access(`ACC_DATA_INC, 1'b0, 1'b0, i[15:0], 1'b0, rd, bi, bo);
      access(`ACC_DATA_INC, 1'b0, 1'b1, ~i[15:0], 1'b0, rd, bi, bo);
      check({31'h0, bo}, 32'h1);
      port_chip_select <= 1'b0;
      repeat (6) @(negedge clk);
      full = port_ready;
      @(posedge clk);
      port_chip_select <= !full;
    end
    check({30'h0, full, i >= 16}, 32'h3);
    stall <= 1'b0;
    for (int n = 0; n < 100 && port_ready !== 1'b0; n++) @(negedge clk);
    check({31'h0, port_ready}, 32'h0);
    @(posedge clk);
    port_chip_select <= 1'b1;
    for (int n = 0; n < 200 && far.n_got != i; n++) @(posedge clk);
    check(far.n_got, i);
    for (int k = 0; k < i; k++) begin
      check(far.got_addr[k], 32'h40 + `ADDR_STEP * k);
      check(far.got_data[k], {~k[15:0], k[15:0]});
    end
  endtask
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    port_chip_select = 1'b1;
    data_strobe_one = 1'b1;
    data_strobe_two = 1'b1;
    address_strobe_n = 1'b1;
    access_select = 2'h0;
    read_write_select = 1'b0;
    halfword_select = 1'b0;
    port_data_bus_in = 16'h0;
    slow = 1'b0;
    stall = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    control_regs;
    reads;
    fill_drain;
    complete_run;
  end
  // watchdog well beyond the expected run of under two thousand cycles
  initial begin
    #3_000_000;
    miscompares++;
    complete_run;
  end
endmodule
bind host_port_strobe_ready host_port_checker chk (.*);
